// [src/pis_pkg.sv]
// Purpose: shared constants and types of the interrupt and standby controller
// Assumes: one system clock, level codes 0 none, 1 low, 2 high, 3 highest
// Notes: source-to-vector map fixes which request flag belongs to which vector
`default_nettype none
package pis_pkg;
  localparam int NSRC = 29;
  localparam int NVEC = 10;
  localparam int NWAKE = 5;
  localparam logic [1:0] LEV_NONE = 2'h0;
  localparam logic [1:0] LEV_LOW = 2'h1;
  localparam logic [1:0] LEV_HIGH = 2'h2;
  localparam logic [1:0] LEV_TOP = 2'h3;
  // vectors below this index may be raised to the highest level
  localparam logic [3:0] TOP_CAPABLE_VECS = 4'h2;
  localparam logic [19:0] VEC_BASE = 20'h00003;
  localparam logic [19:0] VEC_STEP = 20'h00008;
  localparam logic [3:0] SRC_VEC [NSRC] = '{
    4'h0, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3, 4'h3, 4'h3, 4'h3, 4'h4,
    4'h4, 4'h5, 4'h5, 4'h5, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7,
    4'h7, 4'h8, 4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9, 4'h9};
  localparam int SRC_BASE_T0 = 7;
  localparam int SRC_BASE_T1 = 8;
  localparam int SRC_PORT0 = 25;
  // filter settle counts in instruction cycles, stored as count minus one
  localparam logic [6:0] FILT_N1_M1 = 7'h00;
  localparam logic [6:0] FILT_N32_M1 = 7'h1f;
  localparam logic [6:0] FILT_N128_M1 = 7'h7f;
  localparam logic [1:0] FILT_SEL_1 = 2'h0;
  localparam logic [1:0] FILT_SEL_32 = 2'h1;
  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_HALT = 4'h2,
    ST_HOLD = 4'h4,
    ST_XHOLD = 4'h8
  } pis_state_t;
  localparam logic [3:0] RST_ACTIVE = 4'h0;
endpackage
`default_nettype wire

// [src/pis_intc_standby.sv]
// Purpose: interrupt arbitration, nesting and standby entry/exit control
// Assumes: flag clears come from the core; rst is the reset pin, synchronised
// Notes: the remote pin filter feeds the filtered interrupt and timer-zero paths
`default_nettype none
module pis_intc_standby #(
  parameter int ADDR_W = 20
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // request sources and core controls
  input wire logic [pis_pkg::NSRC-1:0] src_req,
  input wire logic [pis_pkg::NSRC-1:0] src_clr,
  input wire logic [pis_pkg::NSRC-1:0] src_en,
  input wire logic [pis_pkg::NVEC-1:0] vec_upper,
  // core vectoring
  output logic irq_req,
  output logic [ADDR_W-1:0] irq_vec_addr,
  output logic [1:0] irq_level,
  input wire logic irq_ack,
  input wire logic irq_ret,
  // standby commands and enables
  input wire logic halt_enter,
  input wire logic hold_enter,
  input wire logic xhold_enter,
  input wire logic xtal_sw_on,
  output logic cpu_exec_en,
  output logic periph_en,
  output logic base_timer_en,
  output logic cf_osc_en,
  output logic rc_osc_en,
  output logic xtal_osc_en,
  // wake pins a, b, c, e, f and their wake levels
  input wire logic ext_irq_pin_a,
  input wire logic ext_irq_pin_b,
  input wire logic ext_irq_pin_c,
  input wire logic ext_irq_pin_e,
  input wire logic ext_irq_pin_f,
  input wire logic [pis_pkg::NWAKE-1:0] wake_level,
  // remote pin filter
  input wire logic remote_rx_shared_pin,
  input wire logic instruction_cycle,
  input wire logic filt_en,
  input wire logic [1:0] filt_sel,
  output logic ext_irq_pin_filtered,
  output logic timer_zero_event_in,
  output logic timer_zero_high_capture_in,
  output logic remote_pin_level
);
  if (ADDR_W < 7) $error("ADDR_W too small for the vector table");

  ////////////////////////////////////////////////////////////////////////////
  // request flags
  logic [pis_pkg::NSRC-1:0] pend_q;
  logic [pis_pkg::NSRC-1:0] pend_d;
  for (genvar s = 0; s < pis_pkg::NSRC; s++)
  begin : g_flag
    // set beats clear so an event in the clearing cycle survives
    always_comb
    begin
      pend_d[s] = src_req[s] | (pend_q[s] & ~src_clr[s]);
    end
    chk_flag_latched: assert property (@(posedge clk) disable iff (rst)
      ce && pend_q[s] && !src_clr[s] |=> pend_q[s])
      else $error("request flag lost while not cleared");
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      pend_q <= '0;
    else if (ce)
      pend_q <= pend_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // arbitration
  logic [3:0] active_q;
  logic [3:0] active_d;
  logic [1:0] cur_lev;
  logic [pis_pkg::NVEC-1:0] vec_pend;
  logic [1:0] vec_lev [pis_pkg::NVEC];
  logic [1:0] best_lev;
  logic [3:0] best_v;
  logic found;
  logic req_q;
  logic blank_q;
  logic [3:0] win_vec_q;
  logic [1:0] win_lev_q;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] addr_d;
  logic better;

  always_comb
  begin
    cur_lev = active_q[3] ? pis_pkg::LEV_TOP :
              active_q[2] ? pis_pkg::LEV_HIGH :
              active_q[1] ? pis_pkg::LEV_LOW : pis_pkg::LEV_NONE;
    vec_pend = '0;
    for (int s = 0; s < pis_pkg::NSRC; s++)
      if (pend_q[s] && src_en[s])
        vec_pend[pis_pkg::SRC_VEC[s]] = 1'b1;
    best_lev = pis_pkg::LEV_NONE;
    best_v = 4'h0;
    for (int v = 0; v < pis_pkg::NVEC; v++)
    begin
      if (!vec_upper[v])
        vec_lev[v] = pis_pkg::LEV_LOW;
      else if (4'(v) < pis_pkg::TOP_CAPABLE_VECS)
        vec_lev[v] = pis_pkg::LEV_TOP;
      else
        vec_lev[v] = pis_pkg::LEV_HIGH;
      // ascending scan with strict compare keeps the smallest vector on ties
      if (vec_pend[v] && vec_lev[v] > cur_lev && vec_lev[v] > best_lev)
      begin
        best_lev = vec_lev[v];
        best_v = 4'(v);
      end
    end
    found = best_lev != pis_pkg::LEV_NONE;
    addr_d = ADDR_W'(pis_pkg::VEC_BASE + pis_pkg::VEC_STEP * 20'(best_v));
  end

  // one blank cycle after an accept hides the stale registered winner
  assign irq_req = req_q & ~blank_q & cpu_exec_en;
  assign irq_vec_addr = addr_q;
  assign irq_level = win_lev_q;

  always_comb
  begin
    active_d = active_q;
    if (irq_ret)
    begin
      if (active_q[3])
        active_d[3] = 1'b0;
      else if (active_q[2])
        active_d[2] = 1'b0;
      else
        active_d[1] = 1'b0;
    end
    if (irq_req && irq_ack)
      active_d[win_lev_q] = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active_q <= pis_pkg::RST_ACTIVE;
      req_q <= 1'b0;
      blank_q <= 1'b0;
      win_vec_q <= 4'h0;
      win_lev_q <= pis_pkg::LEV_NONE;
      addr_q <= '0;
    end
    else if (ce)
    begin
      active_q <= active_d;
      req_q <= found;
      blank_q <= irq_req & irq_ack;
      win_vec_q <= best_v;
      win_lev_q <= best_lev;
      addr_q <= addr_d;
    end
  end

  always_comb
  begin
    better = 1'b0;
    for (int v = 0; v < pis_pkg::NVEC; v++)
      if (found && vec_pend[v] && (vec_lev[v] > best_lev ||
          (vec_lev[v] == best_lev && 4'(v) < best_v)))
        better = 1'b1;
  end
  chk_no_better_winner: assert property (@(posedge clk) disable iff (rst)
    !better)
    else $error("a higher ranked request was passed over");
  chk_top_beats_high: assert property (@(posedge clk) disable iff (rst)
    found && vec_pend[0] && vec_upper[0] && cur_lev < pis_pkg::LEV_TOP
    |-> best_v == 4'h0 && best_lev == pis_pkg::LEV_TOP)
    else $error("highest level request did not win");
  chk_block_equal: assert property (@(posedge clk) disable iff (rst)
    irq_req |-> win_lev_q > cur_lev)
    else $error("request offered at or below the serviced level");
  chk_vec_addr: assert property (@(posedge clk) disable iff (rst)
    irq_req |-> irq_vec_addr == ADDR_W'(20'h00003 + 20'h00008 * 20'(win_vec_q)))
    else $error("vector address does not match the winner");
  chk_ret_restore: assert property (@(posedge clk) disable iff (rst)
    ce && irq_ret && !(irq_req && irq_ack) && cur_lev != 2'h0
    |=> cur_lev < $past(cur_lev) && active_q[1] == $past(active_q[1]) | $past(cur_lev == 2'h1))
    else $error("return did not restore the outer level");

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [5:0] sync1_q;
  logic [5:0] sync2_q;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else if (ce)
    begin
      sync1_q <= {remote_rx_shared_pin, ext_irq_pin_f, ext_irq_pin_e,
                  ext_irq_pin_c, ext_irq_pin_b, ext_irq_pin_a};
      sync2_q <= sync1_q;
    end
  end
  assign remote_pin_level = sync2_q[5];

  ////////////////////////////////////////////////////////////////////////////
  // remote pin noise filter
  logic filt_q;
  logic filt_d;
  logic [6:0] cnt_q;
  logic [6:0] cnt_d;
  logic [6:0] need;
  always_comb
  begin
    need = filt_sel == pis_pkg::FILT_SEL_1 ? pis_pkg::FILT_N1_M1 :
           filt_sel == pis_pkg::FILT_SEL_32 ? pis_pkg::FILT_N32_M1 :
           pis_pkg::FILT_N128_M1;
    filt_d = filt_q;
    cnt_d = cnt_q;
    if (!filt_en)
    begin
      filt_d = sync2_q[5];
      cnt_d = 7'h00;
    end
    else if (sync2_q[5] == filt_q)
      cnt_d = 7'h00;
    else if (instruction_cycle)
    begin
      if (cnt_q >= need)
      begin
        filt_d = sync2_q[5];
        cnt_d = 7'h00;
      end
      else
        cnt_d = cnt_q + 7'h01;
    end
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      filt_q <= 1'b0;
      cnt_q <= 7'h00;
    end
    else if (ce)
    begin
      filt_q <= filt_d;
      cnt_q <= cnt_d;
    end
  end
  assign ext_irq_pin_filtered = filt_q;
  assign timer_zero_event_in = filt_q;
  assign timer_zero_high_capture_in = filt_q;
  chk_filter_settle: assert property (@(posedge clk) disable iff (rst)
    $past(filt_en) && $changed(filt_q) |-> $past(cnt_q) >= $past(need))
    else $error("filter output moved before the settle count");

  ////////////////////////////////////////////////////////////////////////////
  // standby control
  pis_pkg::pis_state_t state_q;
  pis_pkg::pis_state_t state_d;
  logic xtal_keep_q;
  logic xtal_keep_d;
  logic wake_hold;
  logic wake_bt;
  always_comb
  begin
    wake_hold = |(sync2_q[4:0] ~^ wake_level) || pend_q[pis_pkg::SRC_PORT0];
    wake_bt = pend_q[pis_pkg::SRC_BASE_T0] || pend_q[pis_pkg::SRC_BASE_T1];
    state_d = state_q;
    xtal_keep_d = xtal_keep_q;
    unique case (state_q)
      pis_pkg::ST_RUN:
        if (hold_enter)
          state_d = pis_pkg::ST_HOLD;
        else if (xhold_enter)
        begin
          state_d = pis_pkg::ST_XHOLD;
          xtal_keep_d = xtal_sw_on;
        end
        else if (halt_enter)
          state_d = pis_pkg::ST_HALT;
      pis_pkg::ST_HALT:
        if (found)
          state_d = pis_pkg::ST_RUN;
      pis_pkg::ST_HOLD:
        if (wake_hold)
          state_d = pis_pkg::ST_RUN;
      pis_pkg::ST_XHOLD:
        if (wake_hold || wake_bt)
          state_d = pis_pkg::ST_RUN;
      default:
        state_d = pis_pkg::ST_RUN;
    endcase
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_q <= pis_pkg::ST_RUN;
      xtal_keep_q <= 1'b0;
    end
    else if (ce)
    begin
      state_q <= state_d;
      xtal_keep_q <= xtal_keep_d;
    end
  end
  logic awake;
  assign awake = state_q == pis_pkg::ST_RUN || state_q == pis_pkg::ST_HALT;
  assign cpu_exec_en = state_q == pis_pkg::ST_RUN;
  assign periph_en = awake;
  assign base_timer_en = state_q != pis_pkg::ST_HOLD;
  assign cf_osc_en = awake;
  assign rc_osc_en = awake;
  assign xtal_osc_en = awake ? xtal_sw_on :
                       state_q == pis_pkg::ST_XHOLD ? xtal_keep_q : 1'b0;

  chk_halt_wake: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == pis_pkg::ST_HALT && found |=> state_q == pis_pkg::ST_RUN)
    else $error("halt not left on a pending interrupt");
  chk_hold_stops: assert property (@(posedge clk) disable iff (rst)
    state_q == pis_pkg::ST_HOLD |-> !cpu_exec_en && !periph_en && !cf_osc_en
    && !rc_osc_en && !xtal_osc_en && !base_timer_en)
    else $error("hold left something running");
  chk_hold_wake: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == pis_pkg::ST_HOLD && wake_hold |=> state_q == pis_pkg::ST_RUN)
    else $error("hold not left on a wake condition");
  chk_xhold_xtal: assert property (@(posedge clk) disable iff (rst)
    state_q == pis_pkg::ST_XHOLD && $past(state_q) == pis_pkg::ST_RUN
    |-> xtal_osc_en == $past(xtal_sw_on) && base_timer_en && !cf_osc_en)
    else $error("crystal hold did not keep the crystal state");
  chk_xhold_bt: assert property (@(posedge clk) disable iff (rst)
    ce && state_q == pis_pkg::ST_XHOLD && wake_bt |=> state_q == pis_pkg::ST_RUN)
    else $error("crystal hold not left on a base timer source");
endmodule
`default_nettype wire

// [dv/pis_core_model.sv]
// Purpose: core-side model that accepts vector requests
// Assumes: ack is a one-cycle pulse, raised only while irq_req stands
// Notes: ack_dly gives slow answers, counted in cycles of irq_req standing
`default_nettype none
module pis_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // vectoring
  input wire logic irq_req,
  input wire logic ack_on,
  input wire logic [3:0] ack_dly,
  output logic irq_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] wait_q = 4'h0;
  initial irq_ack = 1'b0;
  // one pulse per request: the blank cycle after ack restarts the wait
  always @(negedge clk)
  begin
    if (rst || !irq_req || !ack_on || irq_ack)
    begin
      irq_ack <= 1'b0;
      wait_q <= 4'h0;
    end
    else if (wait_q >= ack_dly)
      irq_ack <= 1'b1;
    else
    begin
      irq_ack <= 1'b0;
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [dv/tb.sv]
// Purpose: self-checking bench of the interrupt and standby controller
// Assumes: stimulus at falling edges, one tick every two clocks
// Notes: vector results are checked by a monitor against a queue of notes
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_errors++; \
  $display("ERROR %0t: got %h exp %h", $time, (a), (b)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [28:0] src_req = '0;
  logic [28:0] src_clr = '0;
  logic [9:0] vec_upper = '0;
  logic irq_ret = 1'b0;
  logic halt_enter = 1'b0;
  logic hold_enter = 1'b0;
  logic xhold_enter = 1'b0;
  logic xtal_sw_on = 1'b0;
  logic [4:0] wpin = '0;
  logic [4:0] wake_level = '0;
  logic rpin = 1'b0;
  logic tick = 1'b0;
  logic filt_en = 1'b0;
  logic [1:0] filt_sel = '0;
  logic ack_on = 1'b0;
  logic [3:0] ack_dly = '0;
  logic irq_ack, irq_req, cpu_exec_en, periph_en, base_timer_en, cf_osc_en;
  logic rc_osc_en, xtal_osc_en, filt_out, t0ev, t0cap, pin_lvl, req_prev;
  logic [19:0] irq_vec_addr;
  logic [1:0] irq_level;
  logic [21:0] exp_q[$];
  logic [21:0] exp_v;
  int n_errors = 0;
  int n_compared = 0;
  int sv[29] = '{0, 1, 2, 2, 2, 3, 3, 3, 3, 4, 4, 5, 5, 5, 6, 6, 6, 7, 7, 7, 7, 8, 8, 8, 8,
    9, 9, 9, 9};
  int k;
  logic up;
  pis_intc_standby #(.ADDR_W(20)) u_dut (.clk(clk), .rst(rst), .ce(1'b1),
    .src_req(src_req), .src_clr(src_clr), .src_en('1), .vec_upper(vec_upper),
    .irq_req(irq_req), .irq_vec_addr(irq_vec_addr), .irq_level(irq_level),
    .irq_ack(irq_ack), .irq_ret(irq_ret), .halt_enter(halt_enter),
    .hold_enter(hold_enter), .xhold_enter(xhold_enter), .xtal_sw_on(xtal_sw_on),
    .cpu_exec_en(cpu_exec_en), .periph_en(periph_en), .base_timer_en(base_timer_en),
    .cf_osc_en(cf_osc_en), .rc_osc_en(rc_osc_en), .xtal_osc_en(xtal_osc_en),
    .ext_irq_pin_a(wpin[0]), .ext_irq_pin_b(wpin[1]), .ext_irq_pin_c(wpin[2]),
    .ext_irq_pin_e(wpin[3]), .ext_irq_pin_f(wpin[4]), .wake_level(wake_level),
    .remote_rx_shared_pin(rpin), .instruction_cycle(tick), .filt_en(filt_en),
    .filt_sel(filt_sel), .ext_irq_pin_filtered(filt_out), .timer_zero_event_in(t0ev),
    .timer_zero_high_capture_in(t0cap), .remote_pin_level(pin_lvl));
  pis_core_model u_core (.clk(clk), .rst(rst), .irq_req(irq_req), .ack_on(ack_on),
    .ack_dly(ack_dly), .irq_ack(irq_ack));
  always #5 clk = ~clk;
  always @(negedge clk) tick <= ~tick;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic results;
    if (n_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic req(input logic [28:0] m);
    src_req = m;
    cyc(1);
    src_req = '0;
  endtask
  task automatic clr(input logic [28:0] m);
    src_clr = m;
    cyc(1);
    src_clr = '0;
    cyc(2);
  endtask
  task automatic note(input logic [1:0] l, input int v);
    exp_q.push_back({l, 20'h00003 + 20'(8 * v)});
  endtask
  task automatic enter(input int m);
    {hold_enter, xhold_enter, halt_enter} = 3'(1 << m);
    cyc(1);
    {hold_enter, xhold_enter, halt_enter} = 3'h0;
  endtask
  task automatic ret;
    irq_ret = 1'b1;
    cyc(1);
    irq_ret = 1'b0;
    cyc(3);
  endtask
  // w: 0 vector request, 1 execution enable, 2 filtered pin
  task automatic wait_on(input int w, input logic v, input int lim, output int n);
    for (n = 0; n < lim; n++)
    begin
      if (w == 0 ? irq_req === v : w == 1 ? cpu_exec_en === v : filt_out === v)
        break;
      cyc(1);
    end
    `CHK(1'(n < lim), 1'b1)
  endtask
  task automatic ack;
    ack_dly = 4'($urandom_range(3));
    ack_on = 1'b1;
    wait_on(0, 1'b0, 20, k);
    ack_on = 1'b0;
  endtask
  // a glitch shorter than the time constant must not pass the filter
  task automatic filt_try(input logic [1:0] sel, input int n);
    filt_sel = sel;
    if (n > 4)
    begin
      rpin = 1'b1;
      cyc($urandom_range(2 * n - 6, 3));
      `CHK(pin_lvl, 1'b1)
      rpin = 1'b0;
      cyc(4);
      `CHK(filt_out, 1'b0)
    end
    rpin = 1'b1;
    wait_on(2, 1'b1, 2 * n + 10, k);
    // filter off: output trails the pin by two sync stages and one register
    `CHK(1'(filt_en ? (k >= 2 * n - 2 && k <= 2 * n + 4) : k == 3), 1'b1)
    `CHK({filt_out, t0ev, t0cap}, 3'h7)
    rpin = 1'b0;
    wait_on(2, 1'b0, 2 * n + 10, k);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(negedge clk)
  begin
    req_prev <= irq_req;
    if (!rst && irq_req === 1'b1 && req_prev !== 1'b1)
    begin
      exp_v = (exp_q.size() > 0) ? exp_q.pop_front() : 22'h3fffff;
      `CHK({irq_level, irq_vec_addr}, exp_v)
    end
  end
  initial
  begin
    #200us;
    n_errors++;
    results();
  end
  initial
  begin
    void'($urandom(32'h47b8));
    cyc(2);
    rst = 1'b0;
    `CHK({irq_req, irq_level, cpu_exec_en, periph_en, cf_osc_en, rc_osc_en}, 7'h0f)
    for (int s = 0; s < 29; s++)
    begin
      up = 1'($urandom_range(1));
      vec_upper = 10'(up) << sv[s];
      note(up ? (sv[s] < 2 ? pis_pkg::LEV_TOP : pis_pkg::LEV_HIGH) : pis_pkg::LEV_LOW, sv[s]);
      req(29'h1 << s);
      wait_on(0, 1'b1, 6, k);
      clr('1);
    end
    vec_upper = 10'h020;
    note(pis_pkg::LEV_HIGH, 5);
    req(29'h0000821);
    wait_on(0, 1'b1, 6, k);
    vec_upper = 10'h021;
    cyc(3);
    `CHK({irq_level, irq_vec_addr}, {pis_pkg::LEV_TOP, 20'h00003})
    vec_upper = 10'h000;
    cyc(3);
    `CHK({irq_level, irq_vec_addr}, {pis_pkg::LEV_LOW, 20'h00003})
    clr('1);
    vec_upper = 10'h004;
    note(pis_pkg::LEV_LOW, 4);
    req(29'h1 << 9);
    wait_on(0, 1'b1, 6, k);
    ack();
    clr(29'h1 << 9);
    req(29'h1 << 14);
    cyc(4);
    `CHK(irq_req, 1'b0)
    note(pis_pkg::LEV_HIGH, 2);
    req(29'h1 << 2);
    wait_on(0, 1'b1, 6, k);
    ack();
    clr(29'h1 << 2);
    ret();
    `CHK(irq_req, 1'b0)
    note(pis_pkg::LEV_LOW, 6);
    ret();
    `CHK(irq_req, 1'b1)
    clr('1);
    enter(0);
    `CHK({cpu_exec_en, periph_en, cf_osc_en}, 3'h3)
    note(pis_pkg::LEV_LOW, 8);
    req(29'h1 << 21);
    wait_on(1, 1'b1, 6, k);
    clr('1);
    xtal_sw_on = 1'b1;
    wake_level = 5'($urandom);
    wpin = ~wake_level;
    cyc(4);
    for (int p = 0; p < 5; p++)
    begin
      enter(2);
      `CHK({cpu_exec_en, periph_en, base_timer_en, cf_osc_en, rc_osc_en, xtal_osc_en}, 6'h00)
      req(29'h1 << 11);
      cyc(4);
      `CHK(cpu_exec_en, 1'b0)
      clr('1);
      wpin[p] = wake_level[p];
      wait_on(1, 1'b1, 8, k);
      wpin[p] = ~wake_level[p];
      cyc(4);
    end
    enter(2);
    note(pis_pkg::LEV_LOW, 9);
    req(29'h1 << 25);
    wait_on(1, 1'b1, 6, k);
    clr('1);
    enter(1);
    `CHK({cpu_exec_en, periph_en, base_timer_en, cf_osc_en, rc_osc_en, xtal_osc_en}, 6'h09)
    note(pis_pkg::LEV_LOW, 3);
    req(29'h1 << 7);
    wait_on(1, 1'b1, 6, k);
    clr('1);
    filt_try(2'h0, 5);
    filt_en = 1'b1;
    filt_try(2'h0, 1);
    filt_try(2'h1, 32);
    filt_try(2'h2, 128);
    `CHK(1'(exp_q.size() == 0), 1'b1)
    results();
  end
endmodule
`default_nettype wire
